/* hw/lfm_top.sv */
// fault supervision and hiccup retry for the led driver
`timescale 1ns/10ps
`include "lfm_defs.svh"
module lfm_top #(
    parameter int HICCUP_CYCLES = `LFM_HICCUP_CYCLES,
    parameter int QUAL_CYCLES = `LFM_QUAL_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic cycle_tick,
    input wire logic boost_mode,
    input wire logic startup_done,
    input wire lfm_pkg::lfm_faults_t faults_in,
    output lfm_pkg::lfm_drive_t drive,
    output logic dimming_switch_drive,
    output logic fault_flag_n_o,
    output logic fault_flag_n_oe
);
    import lfm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // reset release and input synchronisation
    logic [1:0] rst_pipe;
    logic [1:0] next_rst_pipe;
    logic rst_n;
    always_comb begin
        next_rst_pipe = {rst_pipe[0], 1'b1};
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_pipe <= 2'b00;
        end else begin
            rst_pipe <= next_rst_pipe;
        end
    end
    assign rst_n = rst_pipe[1];

    // comparators and the tick come from the analog side, so resync them
    logic [10:0] raw_in;
    logic [10:0] sync_in;
    lfm_faults_t flt;
    logic tick;
    logic boost;
    logic started;
    assign raw_in = {faults_in, cycle_tick, boost_mode, startup_done};
    lfm_sync #(.W(11)) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .din(raw_in),
        .dout(sync_in)
    );
    assign flt = sync_in[10:3];
    assign boost = sync_in[1];
    assign started = sync_in[0];

    // tick edge: one pulse per switching cycle
    logic tick_d;
    logic next_tick_d;
    always_comb begin
        next_tick_d = sync_in[2];
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tick_d <= 1'b0;
        end else begin
            tick_d <= next_tick_d;
        end
    end
    assign tick = sync_in[2] & ~tick_d;

    ////////////////////////////////////////////////////////////////////////
    // cycle by cycle current limit latch, cleared at next cycle start
    logic cl_latch;
    logic next_cl_latch;
    always_comb begin
        next_cl_latch = cl_latch;
        if (tick) begin
            next_cl_latch = 1'b0; // R3
        end
        if (flt.current_limit) begin
            next_cl_latch = 1'b1; // R3
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cl_latch <= 1'b0;
        end else begin
            cl_latch <= next_cl_latch;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // led short qualification and hiccup timer
    lfm_state_t state;
    lfm_state_t next_state;
    logic [`LFM_CNT_W-1:0] cnt;
    logic [`LFM_CNT_W-1:0] next_cnt;
    logic short_seen;
    logic standby_req;
    assign short_seen = flt.led_short & boost; // R4
    // standby faults win, so the hiccup machine is held idle meanwhile;
    // a regulator short before startup is ignored, so it must not abort a retry
    assign standby_req = flt.supply_uv | flt.reg_uv | (flt.reg_short & started)
        | flt.over_voltage | flt.over_temp; // R11
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            LFM_RUN: begin
                next_cnt = '0;
                if (short_seen && !standby_req) begin
                    next_state = LFM_QUAL;
                end
            end
            LFM_QUAL: begin
                if (!short_seen || standby_req) begin
                    next_state = LFM_RUN;
                    next_cnt = '0;
                end else if (tick) begin
                    if (cnt == `LFM_CNT_W'(QUAL_CYCLES - 1)) begin
                        next_state = LFM_HICCUP; // R9
                        next_cnt = '0;
                    end else begin
                        next_cnt = cnt + 1'b1;
                    end
                end
            end
            LFM_HICCUP: begin
                if (standby_req) begin
                    next_state = LFM_RUN;
                    next_cnt = '0;
                end else if (tick) begin
                    if (cnt == `LFM_CNT_W'(HICCUP_CYCLES - 1)) begin
                        next_state = LFM_RUN; // R4
                        next_cnt = '0;
                    end else begin
                        next_cnt = cnt + 1'b1; // R11
                    end
                end
            end
            default: begin
                next_state = LFM_RUN;
                next_cnt = '0;
            end
        endcase
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= LFM_RUN;
            cnt <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // response priority and outputs
    logic hiccup;
    logic reg_short_rep;
    logic flag_req;
    lfm_drive_t next_drive;
    logic next_dim;
    logic next_flag_oe;
    assign hiccup = (state == LFM_HICCUP);
    assign reg_short_rep = flt.reg_short & started; // R6
    // supply undervoltage and regulator undervoltage are silent on the flag
    assign flag_req = reg_short_rep | flt.over_voltage | flt.over_temp | hiccup
        | flt.freq_short; // R7
    always_comb begin
        next_drive.standby = standby_req; // R2
        next_drive.comp_reset = next_drive.standby | hiccup; // R1
        next_drive.gate_off = next_drive.standby | hiccup | flt.freq_short | cl_latch
            | flt.current_limit; // R5
        next_drive.dim_off = flt.supply_uv | flt.over_voltage | hiccup; // R8
        next_dim = ~next_drive.dim_off;
        next_flag_oe = ~flag_req; // R7
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            drive <= 4'b1111;
            dimming_switch_drive <= 1'b0;
            fault_flag_n_oe <= 1'b1;
        end else begin
            drive <= next_drive;
            dimming_switch_drive <= next_dim;
            fault_flag_n_oe <= next_flag_oe; // R10
        end
    end
    assign fault_flag_n_o = 1'b0; // open drain only ever pulls low

    ////////////////////////////////////////////////////////////////////////
    // checks
    chk_uv_drives: assert property (@(posedge mclk) disable iff (!rst_n)
        flt.supply_uv |=> drive.gate_off && !dimming_switch_drive && drive.comp_reset) // R1
        else $error("undervoltage did not force drives off");
    chk_uv_silent: assert property (@(posedge mclk) disable iff (!rst_n)
        (flt.supply_uv && !flag_req) |=> fault_flag_n_oe) // R1
        else $error("undervoltage pulled the flag");
    chk_standby_entry: assert property (@(posedge mclk) disable iff (!rst_n)
        (flt.over_temp || flt.reg_uv) |=> drive.standby && drive.gate_off) // R2
        else $error("standby fault did not enter standby");
    chk_cl_cycle: assert property (@(posedge mclk) disable iff (!rst_n)
        (flt.current_limit && !flag_req) |=> drive.gate_off && fault_flag_n_oe) // R3
        else $error("current limit response wrong");
    chk_hiccup_len: assert property (@(posedge mclk) disable iff (!rst_n)
        (state == LFM_HICCUP && tick && cnt == `LFM_CNT_W'(HICCUP_CYCLES - 1)
            && !standby_req) |=> state == LFM_RUN) // R4
        else $error("hiccup did not end on time");
    chk_freq_flag: assert property (@(posedge mclk) disable iff (!rst_n)
        flt.freq_short |=> drive.gate_off && !fault_flag_n_oe) // R5
        else $error("frequency short not flagged");
    chk_vdd_gate: assert property (@(posedge mclk) disable iff (!rst_n)
        (flt.reg_short && !started && !flt.over_voltage && !flt.over_temp
            && !flt.freq_short && !hiccup) |=> fault_flag_n_oe) // R6
        else $error("regulator short flagged before startup");
    chk_ovp_all: assert property (@(posedge mclk) disable iff (!rst_n)
        flt.over_voltage |=> !dimming_switch_drive && !fault_flag_n_oe && drive.gate_off) // R8
        else $error("overvoltage response incomplete");
    chk_qual_wait: assert property (@(posedge mclk) disable iff (!rst_n)
        (state == LFM_RUN) |=> state != LFM_HICCUP) // R9
        else $error("hiccup entered without qualification");
    chk_standby_prio: assert property (@(posedge mclk) disable iff (!rst_n)
        standby_req |=> state == LFM_RUN) // R11
        else $error("hiccup ran during standby");
    chk_temp_flag: assert property (@(posedge mclk) disable iff (!rst_n)
        flt.over_temp |=> !fault_flag_n_oe && drive.standby) // R10
        else $error("overtemperature not flagged");
    cov_hiccup: cover property (@(posedge mclk) disable iff (!rst_n) state == LFM_HICCUP);
    cov_cl: cover property (@(posedge mclk) disable iff (!rst_n) cl_latch && tick);
    cov_ovp: cover property (@(posedge mclk) disable iff (!rst_n) flt.over_voltage);
endmodule : lfm_top

/* common/lfm_defs.svh */
// timing and encoding constants for the led fault manager
// Summary of operation
// R1: supply undervoltage forces both drives low, standby, compensation reset, flag released.
// R2: regulator low, pin short, overvoltage, overtemperature force gate low, standby, reset.
// R3: switch current limit blanks gate for rest of cycle only, no flag.
// R4: boost LED short forces both drives low, flags, retries after 16,000 cycles.
// R5: frequency above 2.5MHz holds gate low and flags until it falls back.
// R6: regulator pin short reported only after startup, cleared when rail recovers.
// R7: fault flag is open drain, pulled low on reported fault; host pulls up.
// R8: overvoltage pulls gate, dimming drive and flag low until below hysteresis.
// R9: LED short hiccup starts after overcurrent persists about two switching cycles.
// R10: overtemperature enters standby and flags until release threshold clears.
// R11: retry timer counts ticks from sync reset; standby beats hiccup beats limit.
`ifndef LFM_DEFS_SVH
`define LFM_DEFS_SVH
`define LFM_HICCUP_CYCLES 16000
`define LFM_QUAL_CYCLES 2
`define LFM_CNT_W 14
`endif

/* common/lfm_pkg.sv */
// types shared by the led fault manager
package lfm_pkg;
    typedef struct packed {
        logic supply_uv;
        logic reg_uv;
        logic reg_short;
        logic over_voltage;
        logic current_limit;
        logic led_short;
        logic freq_short;
        logic over_temp;
    } lfm_faults_t;
    typedef struct packed {
        logic gate_off;
        logic dim_off;
        logic standby;
        logic comp_reset;
    } lfm_drive_t;
    typedef enum logic [1:0] {
        LFM_RUN = 2'b00,
        LFM_QUAL = 2'b01,
        LFM_HICCUP = 2'b10
    } lfm_state_t;
endpackage : lfm_pkg

/* hw/lfm_sync.sv */
// two flop synchroniser bank for analog comparator levels
`timescale 1ns/10ps
module lfm_sync #(
    parameter int W = 8
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] stage1;
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_dout;
    // first stage is read only by the second
    always_comb begin
        next_stage1 = din;
        next_dout = stage1;
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            dout <= '0;
        end else begin
            stage1 <= next_stage1;
            dout <= next_dout;
        end
    end
endmodule : lfm_sync

/* verification/lfm_host_model.sv */
// host side of the open drain fault flag with its pull-up
`timescale 1ns/10ps
module lfm_host_model (
    input wire logic fault_flag_n_o,
    input wire logic fault_flag_n_oe,
    output logic pin_level
);
    // the pull-up wins whenever the device releases the pin
    always_comb begin
        pin_level = (fault_flag_n_oe === 1'b0) ? fault_flag_n_o : 1'b1;
    end
endmodule : lfm_host_model

/* verification/test_lfm_top.sv */
// self-checking bench for the led fault manager
`timescale 1ns/10ps
module test_lfm_top;
    import lfm_pkg::*;
    localparam int HIC = 20;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic cycle_tick = 1'b0;
    logic boost_mode = 1'b0;
    logic startup_done = 1'b1;
    lfm_faults_t f = '0;
    lfm_drive_t drive;
    logic dimming_switch_drive;
    logic fault_flag_n_o;
    logic fault_flag_n_oe;
    logic pin_level;
    int miscompares = 0;
    int samples_checked = 0;
    // short retry count keeps the run brief
    lfm_top #(.HICCUP_CYCLES(HIC), .QUAL_CYCLES(2)) dut (
        .mclk(mclk), .rst_b(rst_b), .cycle_tick(cycle_tick), .boost_mode(boost_mode),
        .startup_done(startup_done), .faults_in(f), .drive(drive),
        .dimming_switch_drive(dimming_switch_drive), .fault_flag_n_o(fault_flag_n_o),
        .fault_flag_n_oe(fault_flag_n_oe)
    );
    lfm_host_model host (
        .fault_flag_n_o(fault_flag_n_o), .fault_flag_n_oe(fault_flag_n_oe),
        .pin_level(pin_level)
    );
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : wait_cyc
    // drive outputs and the pulled-up pin against expectation
    task automatic chk(input logic [3:0] exp_drv, input logic exp_pin);
        samples_checked++;
        if (drive !== exp_drv || pin_level !== exp_pin || dimming_switch_drive !== ~exp_drv[2]) begin
            miscompares++;
            $display("wrong value at %0t: drive %b pin %b dim %b, expected %b %b", $time,
                     drive, pin_level, dimming_switch_drive, exp_drv, exp_pin);
        end
    endtask : chk
    // one switching cycle, long enough for the synchroniser to see both levels
    task automatic tick(input int n);
        repeat (n) begin
            cycle_tick = 1'b1;
            wait_cyc(4);
            cycle_tick = 1'b0;
            wait_cyc(4);
        end
    endtask : tick
    // raise a fault level, check the response, drop it and check recovery
    task automatic apply(input logic [7:0] fb, input logic [3:0] exp_drv, input logic exp_pin);
        f = fb;
        wait_cyc(5);
        chk(exp_drv, exp_pin);
        f = '0;
        wait_cyc(5);
        tick(1);
        chk(4'b0000, 1'b1);
    endtask : apply
    ////////////////////////////////////////////////////////////////////////////////
    task automatic limit_test;
        f.current_limit = 1'b1;
        wait_cyc(5);
        chk(4'b1000, 1'b1);
        f.current_limit = 1'b0;
        wait_cyc(5);
        chk(4'b1000, 1'b1);
        tick(1);
        chk(4'b0000, 1'b1);
    endtask : limit_test
    task automatic pin_short_test;
        startup_done = 1'b0;
        apply(8'h20, 4'b0000, 1'b1);
        startup_done = 1'b1;
        apply(8'h20, 4'b1011, 1'b0);
    endtask : pin_short_test
    task automatic hiccup_test;
        boost_mode = 1'b0;
        f.led_short = 1'b1;
        tick(5);
        chk(4'b0000, 1'b1);
        boost_mode = 1'b1;
        tick(1);
        chk(4'b0000, 1'b1);
        tick(2);
        chk(4'b1101, 1'b0);
        // short persists: the retry requalifies and the hiccup repeats
        tick(HIC - 1);
        chk(4'b1101, 1'b0);
        tick(1);
        chk(4'b0000, 1'b1);
        tick(2);
        chk(4'b1101, 1'b0);
        f.led_short = 1'b0;
        tick(HIC - 1);
        chk(4'b1101, 1'b0);
        tick(1);
        chk(4'b0000, 1'b1);
    endtask : hiccup_test
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        wait_cyc(20);
        chk(4'b1111, 1'b1);
        rst_b = 1'b1;
        wait_cyc(5);
        chk(4'b0000, 1'b1);
        apply(8'h80, 4'b1111, 1'b1);
        apply(8'h40, 4'b1011, 1'b1);
        apply(8'h10, 4'b1111, 1'b0);
        apply(8'h01, 4'b1011, 1'b0);
        apply(8'h02, 4'b1000, 1'b0);
        apply(8'h09, 4'b1011, 1'b0);
        limit_test();
        pin_short_test();
        hiccup_test();
        end_of_test();
    end
    // the tests take about 600 cycles, so a hang is cut short at 2000
    initial begin
        wait_cyc(2000);
        miscompares++;
        end_of_test();
    end
endmodule : test_lfm_top
